// *** include/dst_regs.svh ***
/*
 * register offsets, field positions, reset values and timing counts of the
 * drive supervision timers. assumes a 100 MHz mclk and byte addresses on a
 * plain register port with one 32-bit word per register.
 */
//************************************************************
// Summary of operation
//************************************************************
// Summary of operation
// - over-torque time past half the detect time raises alarm, motor keeps running.
// - over-torque level zero disables both alarm and trip.
// - over-torque time past full detect time records fault and stops output.
// - detect time 0.1 to 20.0 s in 0.1 s steps, default 1.0 s.
// - over-torque time starts when current first exceeds the threshold.
// - mode 0-3 picks reached-frequency or running detection, alarm or stop.
// - counter retention 1 keeps counter over power loss, 0 clears it.
// - aux pump count 0-2, each pump on its own output contact.
// - two pumps, one on duty: swap duty after set minutes, default 60.
// - duty swap holds both outputs off for interlock time 1-250 s, default 5.
// - run at high speed for high-speed time starts an aux pump.
// - run at low speed for low-speed time stops an aux pump.
// - sleep entry holds sleep frequency 1-250 s, default 20 s.
// - fault restart enabled restarts after trip outlasts restart delay, default 1.0.
// - momentary restart 0 never restarts after outage, 1 restarts with tracking.
// - outage longer than allowable time (0.1-5.0 s) waits for a start command.
// - over-current or over-voltage resets and restarts, normal or tracking start.
// - restart limit 0-10, 0 disables; reload after 60 s clean; limit locks.
// - PID path active only while the PID input is asserted.
// - gain 0.0-1000.0 % default 100 %; integral 0.1-3600.0 s default 5.0.
// - derivative time 0.01-10.00 s; zero disables the derivative term.
// - energy saving above zero reduces voltage only at constant speed.
`ifndef DST_REGS_SVH
`define DST_REGS_SVH
// offsets
`define DST_A_CTRL 6'h00
`define DST_A_OT 6'h04
`define DST_A_PUMP 6'h08
`define DST_A_SPEED 6'h0C
`define DST_A_RST 6'h10
`define DST_A_PID 6'h14
`define DST_A_PIDT 6'h18
`define DST_A_ESAVE 6'h1C
`define DST_A_COUNT 6'h20
`define DST_A_STAT 6'h24
`define DST_A_CMD 6'h28
// field positions
`define DST_F_MODE 0
`define DST_F_RETAIN 2
`define DST_F_NPUMP 3
`define DST_F_FREN 5
`define DST_F_MOMR 6
`define DST_F_TRACK 7
`define DST_F_LO 0
`define DST_F_MID 8
`define DST_F_HI 16
// reset values, time fields in 0.1 s, 1 s or minutes as noted
`define DST_R_OTTIME 8'h0A
`define DST_R_ALTMIN 14'h003C
`define DST_R_INTLK 8'h05
`define DST_R_HIRUN 8'h3C
`define DST_R_LORUN 8'h3C
`define DST_R_SLEEP 8'h14
`define DST_R_FRD 8'h0A
`define DST_R_OUTAGE 8'h05
`define DST_R_GAIN 14'h03E8
`define DST_R_ITIME 16'h0032
// timing
`define DST_CLK_NS 10
`define DST_TICK_NS 100000000
`define DST_TICKS_PER_S 16'h000A
`define DST_MIN_TICKS 23'h000258
`define DST_CLEAN_TICKS 16'h0258
// fault codes
`define DST_FC_NONE 4'h0
`define DST_FC_OT 4'h1
`define DST_FC_OC 4'h2
`define DST_FC_OV 4'h3
`endif

// *** include/dst_pkg.sv ***
/*
 * types of the drive supervision timers.
 * assumes dst_regs.svh holds the numbers.
 */
package dst_pkg;
  typedef enum logic [2:0] {DST_STOP, DST_RUN, DST_OUTAGE, DST_FAULT, DST_LOCK} dst_state_t;
  // asynchronous pins
  typedef struct packed {
    logic power_ok;
    logic pid_in;
    logic oc;
    logic ov;
  } dst_pins_t;
  // drive-facing outputs
  typedef struct packed {
    logic ot_alarm;
    logic run_enable;
    logic track_start;
    logic [1:0] pump;
    logic sleep_hold;
    logic pid_en;
    logic pid_d_en;
    logic esave_en;
    logic [3:0] fault_code;
  } dst_out_t;
endpackage

// *** rtl/dst_core.sv ***
/*
 * drive supervision timers: over-torque, counter retention, pump staging,
 * sleep hold, restart sequencing and PID/energy-saving enables.
 * assumes current and speed flags come from logic on mclk, pins are async.
 */
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "dst_regs.svh"
module dst_core #(
  parameter int unsigned TICK_CYCLES = `DST_TICK_NS / `DST_CLK_NS
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // drive status on mclk
  input wire logic [7:0] cur_pct,
  input wire logic at_freq,
  input wire logic running,
  input wire logic at_high,
  input wire logic at_low,
  input wire logic const_speed,
  input wire logic sleep_req,
  input wire logic count_pulse,
  input wire logic start_cmd,
  // asynchronous pins
  input wire dst_pkg::dst_pins_t pins,
  // outputs
  output dst_pkg::dst_out_t o
);
  function automatic logic [15:0] inc16(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction
  function automatic logic [15:0] secs(input logic [7:0] s);
    return 16'(s) * `DST_TICKS_PER_S;
  endfunction
  function automatic logic [15:0] clampv(input logic [15:0] v, lo, hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  dst_pkg::dst_pins_t pins_m, pins_s;
  dst_pkg::dst_state_t state;
  logic [31:0] pre;
  logic tick, pwr_prev, pwr_fall, fault_reset, run;
  logic [1:0] ot_mode, aux_pump_count, pumps_on;
  logic counter_retention, fault_restart_en, momentary_stop_restart, track_on_restart;
  logic [7:0] overtorque_level, overtorque_detect_time, pump_interlock_time;
  logic [7:0] high_speed_run_time, low_speed_run_time, sleep_freq_hold_time;
  logic [7:0] fault_restart_delay, allowable_outage_time;
  logic [3:0] auto_restart_limit, retries, energy_saving_level;
  logic [13:0] pump_alternation_minutes, pid_prop_gain;
  logic [15:0] pid_integral_time, cnt, ot_acc, t, clean_t, hs_t, ls_t, il_t, sl_t;
  logic [9:0] pid_derivative_time;
  logic [22:0] alt_t;
  logic ot_en, ot_over, ot_trip, il, duty, alt_done, restart_ok;

  //************************************************************
  // pin synchroniser and tick
  //************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pins_m <= '0;
      pins_s <= '0;
    end else if (ce) begin
      pins_m <= pins;
      pins_s <= pins_m;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= (pre == TICK_CYCLES - 1);
      pre <= (pre == TICK_CYCLES - 1) ? '0 : pre + 32'h1;
    end
  end

  //************************************************************
  // registers
  //************************************************************
  assign fault_reset = ce && wr && addr == `DST_A_CMD && wdata[0];
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ot_mode <= '0;
      counter_retention <= 1'b0;
      aux_pump_count <= '0;
      fault_restart_en <= 1'b0;
      momentary_stop_restart <= 1'b0;
      track_on_restart <= 1'b0;
      overtorque_level <= '0;
      overtorque_detect_time <= `DST_R_OTTIME;
      pump_alternation_minutes <= `DST_R_ALTMIN;
      pump_interlock_time <= `DST_R_INTLK;
      high_speed_run_time <= `DST_R_HIRUN;
      low_speed_run_time <= `DST_R_LORUN;
      sleep_freq_hold_time <= `DST_R_SLEEP;
      fault_restart_delay <= `DST_R_FRD;
      allowable_outage_time <= `DST_R_OUTAGE;
      auto_restart_limit <= '0;
      pid_prop_gain <= `DST_R_GAIN;
      pid_integral_time <= `DST_R_ITIME;
      pid_derivative_time <= '0;
      energy_saving_level <= '0;
    end else if (ce && wr) begin
      unique case (addr)
        `DST_A_CTRL: begin
          ot_mode <= wdata[`DST_F_MODE +: 2];
          counter_retention <= wdata[`DST_F_RETAIN];
          aux_pump_count <= 2'(clampv(16'(wdata[`DST_F_NPUMP +: 2]), 16'h0, 16'h2));
          fault_restart_en <= wdata[`DST_F_FREN];
          momentary_stop_restart <= wdata[`DST_F_MOMR];
          track_on_restart <= wdata[`DST_F_TRACK];
        end
        `DST_A_OT: begin
          overtorque_level <= 8'(clampv(16'(wdata[`DST_F_LO +: 8]), 16'h0, 16'h00C8));
          overtorque_detect_time <= 8'(clampv(16'(wdata[`DST_F_MID +: 8]), 16'h1, 16'h00C8));
        end
        `DST_A_PUMP: begin
          pump_alternation_minutes <= 14'(clampv(16'(wdata[`DST_F_LO +: 14]), 16'h1, 16'h2328));
          pump_interlock_time <= 8'(clampv(16'(wdata[`DST_F_HI +: 8]), 16'h1, 16'h00FA));
        end
        `DST_A_SPEED: begin
          high_speed_run_time <= 8'(clampv(16'(wdata[`DST_F_LO +: 8]), 16'h1, 16'h00FA));
          low_speed_run_time <= 8'(clampv(16'(wdata[`DST_F_MID +: 8]), 16'h1, 16'h00FA));
          sleep_freq_hold_time <= 8'(clampv(16'(wdata[`DST_F_HI +: 8]), 16'h1, 16'h00FA));
        end
        `DST_A_RST: begin
          fault_restart_delay <= wdata[`DST_F_LO +: 8];
          allowable_outage_time <= 8'(clampv(16'(wdata[`DST_F_MID +: 8]), 16'h1, 16'h0032));
          auto_restart_limit <= 4'(clampv(16'(wdata[`DST_F_HI +: 4]), 16'h0, 16'hA));
        end
        `DST_A_PID: pid_prop_gain <= 14'(clampv(16'(wdata[`DST_F_LO +: 14]), 16'h0, 16'h2710));
        `DST_A_PIDT: begin
          pid_integral_time <= clampv(wdata[`DST_F_LO +: 16], 16'h1, 16'h8CA0);
          pid_derivative_time <= 10'(clampv(16'(wdata[`DST_F_HI +: 10]), 16'h0, 16'h03E8));
        end
        `DST_A_ESAVE: energy_saving_level <= 4'(clampv(16'(wdata[3:0]), 16'h0, 16'hA));
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= '0;
      if (rd) begin
        unique case (addr)
          `DST_A_CTRL: rdata <= {24'h0, track_on_restart, momentary_stop_restart,
                                 fault_restart_en, aux_pump_count, counter_retention, ot_mode};
          `DST_A_OT: rdata <= {16'h0, overtorque_detect_time, overtorque_level};
          `DST_A_PUMP: rdata <= {8'h0, pump_interlock_time, 2'h0, pump_alternation_minutes};
          `DST_A_SPEED: rdata <= {8'h0, sleep_freq_hold_time, low_speed_run_time,
                                  high_speed_run_time};
          `DST_A_RST: rdata <= {12'h0, auto_restart_limit, allowable_outage_time,
                                fault_restart_delay};
          `DST_A_PID: rdata <= {18'h0, pid_prop_gain};
          `DST_A_PIDT: rdata <= {6'h0, pid_derivative_time, pid_integral_time};
          `DST_A_ESAVE: rdata <= {28'h0, energy_saving_level};
          `DST_A_COUNT: rdata <= {16'h0, cnt};
          `DST_A_STAT: rdata <= {16'h0, o.fault_code, retries, 1'b0, state, pumps_on, il,
                                 o.ot_alarm};
          default: rdata <= '0;
        endcase
      end
    end
  end

  //************************************************************
  // over-torque
  //************************************************************
  assign ot_en = overtorque_level != 8'h00 && (ot_mode[1] ? running : at_freq);
  assign ot_over = ot_en && cur_pct > overtorque_level;
  assign ot_trip = ot_over && ot_mode[0] && ot_acc > 16'(overtorque_detect_time);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ot_acc <= '0;
      o.ot_alarm <= 1'b0;
    end else if (ce) begin
      ot_acc <= !ot_over ? '0 : (tick ? inc16(ot_acc) : ot_acc);
      o.ot_alarm <= ot_over && {ot_acc, 1'b0} > 17'(overtorque_detect_time);
    end
  end

  //************************************************************
  // event counter
  //************************************************************
  assign pwr_fall = pwr_prev && !pins_s.power_ok;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pwr_prev <= 1'b0;
      cnt <= '0;
    end else if (ce) begin
      pwr_prev <= pins_s.power_ok;
      if (wr && addr == `DST_A_COUNT)
        cnt <= wdata[15:0];
      else if (pwr_fall && !counter_retention)
        cnt <= '0;
      else if (count_pulse && pins_s.power_ok)
        cnt <= cnt + 16'h0001;
    end
  end

  //************************************************************
  // run, outage and fault sequencing
  //************************************************************
  assign run = state == dst_pkg::DST_RUN;
  // a fault restart needs a nonzero limit and room left in it
  assign restart_ok = auto_restart_limit != 4'h0 && retries < auto_restart_limit
                      && (fault_restart_en || o.fault_code != `DST_FC_OT);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= dst_pkg::DST_STOP;
      t <= '0;
      clean_t <= '0;
      retries <= '0;
      o.fault_code <= `DST_FC_NONE;
      o.track_start <= 1'b0;
    end else if (ce) begin
      o.track_start <= 1'b0;
      t <= tick ? inc16(t) : t;
      unique case (state)
        dst_pkg::DST_STOP: begin
          if (start_cmd && pins_s.power_ok)
            state <= dst_pkg::DST_RUN;
        end
        dst_pkg::DST_RUN: begin
          t <= '0;
          clean_t <= tick ? inc16(clean_t) : clean_t;
          if (clean_t >= `DST_CLEAN_TICKS) begin
            retries <= '0;
            clean_t <= '0;
          end
          if (!pins_s.power_ok) begin
            state <= dst_pkg::DST_OUTAGE;
          end else if (pins_s.oc || pins_s.ov || ot_trip) begin
            state <= dst_pkg::DST_FAULT;
            clean_t <= '0;
            o.fault_code <= ot_trip ? `DST_FC_OT : (pins_s.oc ? `DST_FC_OC : `DST_FC_OV);
          end
        end
        dst_pkg::DST_OUTAGE: begin
          if (pins_s.power_ok) begin
            // beyond the allowed outage only a fresh start command runs again
            if (momentary_stop_restart && t <= 16'(allowable_outage_time)) begin
              state <= dst_pkg::DST_RUN;
              o.track_start <= 1'b1;
            end else
              state <= dst_pkg::DST_STOP;
          end
        end
        dst_pkg::DST_FAULT: begin
          if (fault_reset) begin
            state <= dst_pkg::DST_STOP;
            o.fault_code <= `DST_FC_NONE;
          end else if (auto_restart_limit != 4'h0 && retries >= auto_restart_limit)
            state <= dst_pkg::DST_LOCK;
          else if (restart_ok && t > 16'(fault_restart_delay) && pins_s.power_ok) begin
            state <= dst_pkg::DST_RUN;
            retries <= retries + 4'h1;
            o.track_start <= track_on_restart;
          end
        end
        dst_pkg::DST_LOCK: begin
          if (fault_reset) begin
            state <= dst_pkg::DST_STOP;
            retries <= '0;
            o.fault_code <= `DST_FC_NONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      o.run_enable <= 1'b0;
    else if (ce)
      o.run_enable <= run;
  end

  //************************************************************
  // auxiliary pumps
  //************************************************************
  assign alt_done = alt_t >= 23'(pump_alternation_minutes) * `DST_MIN_TICKS;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pumps_on <= '0;
      hs_t <= '0;
      ls_t <= '0;
      alt_t <= '0;
      il <= 1'b0;
      il_t <= '0;
      duty <= 1'b0;
      o.pump <= '0;
    end else if (ce) begin
      hs_t <= (run && at_high && pumps_on < aux_pump_count) ? (tick ? inc16(hs_t) : hs_t) : '0;
      ls_t <= (run && at_low && pumps_on != 2'h0) ? (tick ? inc16(ls_t) : ls_t) : '0;
      if (!run || pumps_on > aux_pump_count)
        pumps_on <= '0;
      else if (hs_t >= secs(high_speed_run_time)) begin
        pumps_on <= pumps_on + 2'h1;
        hs_t <= '0;
      end else if (ls_t >= secs(low_speed_run_time)) begin
        pumps_on <= pumps_on - 2'h1;
        ls_t <= '0;
      end
      if (il) begin
        alt_t <= '0;
        il_t <= tick ? inc16(il_t) : il_t;
        if (il_t >= secs(pump_interlock_time)) begin
          il <= 1'b0;
          duty <= !duty;
        end
      end else if (run && aux_pump_count == 2'h2 && pumps_on == 2'h1) begin
        alt_t <= tick ? alt_t + 23'h1 : alt_t;
        if (alt_done) begin
          il <= 1'b1;
          il_t <= '0;
        end
      end else
        alt_t <= '0;
      // each pump owns one contact; the interlock drops both
      o.pump <= (il || pumps_on == 2'h0) ? 2'b00 :
                (pumps_on == 2'h2) ? 2'b11 : (duty ? 2'b10 : 2'b01);
    end
  end

  //************************************************************
  // sleep hold, PID and energy saving
  //************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sl_t <= '0;
      o.sleep_hold <= 1'b0;
      o.pid_en <= 1'b0;
      o.pid_d_en <= 1'b0;
      o.esave_en <= 1'b0;
    end else if (ce) begin
      sl_t <= !(sleep_req && run) ? '0 : (tick ? inc16(sl_t) : sl_t);
      o.sleep_hold <= sleep_req && run && sl_t < secs(sleep_freq_hold_time);
      o.pid_en <= pins_s.pid_in && run;
      o.pid_d_en <= pins_s.pid_in && run && pid_derivative_time != 10'h000;
      o.esave_en <= energy_saving_level != 4'h0 && run && const_speed;
    end
  end

  //************************************************************
  // assertions
  //************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_il_enter;
    ce && !il && run && aux_pump_count == 2'h2 && pumps_on == 2'h1 && alt_done;
  endsequence
  sequence s_fault_lost;
    ce && state == dst_pkg::DST_FAULT && auto_restart_limit == 4'h0;
  endsequence
  AST_OT_OFF: assert property (ce && overtorque_level == 8'h00 |=> !o.ot_alarm)
    else $error("over-torque alarm with level zero");
  AST_OT_CLR: assert property (ce && !ot_over |=> ot_acc == 16'h0 && !o.ot_alarm)
    else $error("over-torque time not cleared");
  AST_OT_TRIP: assert property (ce && run && pins_s.power_ok && ot_trip
    |=> state == dst_pkg::DST_FAULT && o.fault_code == `DST_FC_OT)
    else $error("over-torque trip missed");
  AST_CNT_LOSE: assert property (ce && pwr_fall && !counter_retention
    && !(wr && addr == `DST_A_COUNT) |=> cnt == 16'h0)
    else $error("counter kept without retention");
  AST_CNT_KEEP: assert property (ce && pwr_fall && counter_retention
    && !(wr && addr == `DST_A_COUNT) |=> $stable(cnt))
    else $error("counter lost with retention");
  AST_INTLK: assert property (s_il_enter |=> ##1 o.pump == 2'b00)
    else $error("pump outputs active in interlock");
  AST_NO_AUTO: assert property (s_fault_lost |=> state != dst_pkg::DST_RUN)
    else $error("restart with limit zero");
  AST_LOCK: assert property (ce && state == dst_pkg::DST_LOCK && !fault_reset
    |=> state == dst_pkg::DST_LOCK)
    else $error("lock left without reset");
  AST_OUTAGE: assert property (ce && state == dst_pkg::DST_OUTAGE && pins_s.power_ok
    && t > 16'(allowable_outage_time) |=> state == dst_pkg::DST_STOP ##1 !o.run_enable)
    else $error("restart after long outage");
  AST_PID: assert property (ce && !pins_s.pid_in |=> !o.pid_en && !o.pid_d_en)
    else $error("PID active without input");
  // the enable was computed from last cycle's setting, so compare against that
  AST_DERIV: assert property (o.pid_d_en
    |-> o.pid_en && $past(pid_derivative_time) != 10'h000)
    else $error("derivative enabled wrongly");
endmodule

// *** bench/dst_drive_model.sv ***
/*
 * drive-side model: motor current sensing and running feedback.
 * assumes the core's outputs are registered on mclk.
 */
`timescale 1ns/100ps
module dst_drive_model (
  // core outputs
  input wire dst_pkg::dst_out_t o,
  // load set by the bench
  input wire logic [7:0] load_pct,
  // measured feedback
  output logic [7:0] cur_pct,
  output logic running,
  output logic at_freq
);
  // no current once output is removed, so a trip cannot retrigger itself
  assign cur_pct = o.run_enable ? load_pct : 8'h00;
  assign running = o.run_enable;
  assign at_freq = o.run_enable;
endmodule

// *** bench/tb.sv ***
/*
 * self-checking bench of the supervision timers over the register port.
 * assumes a short prescaler; drive feedback comes from dst_drive_model.
 */
`timescale 1ns/100ps
`include "dst_regs.svh"
module tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0] cur_pct, load_pct = 8'h00;
  logic at_freq, running;
  logic at_high = 1'b0, at_low = 1'b0, const_speed = 1'b0, start_cmd = 1'b0;
  logic sleep_req = 1'b0;
  dst_pkg::dst_pins_t pins = '0;
  dst_pkg::dst_out_t o;
  int n_mismatch = 0;
  int n_compared = 0;
  int i;
  always #5 mclk = ~mclk;
  // short prescaler keeps every timer but the pump alternation and the 60 s retry reload within a few hundred cycles; one minute takes 2400
  dst_core #(.TICK_CYCLES(4)) dut (.mclk(mclk), .nrst(nrst), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cur_pct(cur_pct), .at_freq(at_freq),
    .running(running), .at_high(at_high), .at_low(at_low), .const_speed(const_speed),
    .sleep_req(sleep_req), .count_pulse(1'b0), .start_cmd(start_cmd), .pins(pins), .o(o));
  dst_drive_model model (.o(o), .load_pct(load_pct), .cur_pct(cur_pct),
    .running(running), .at_freq(at_freq));
  //************************************************************
  // tasks
  //************************************************************
  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  //************************************************************
  // scenarios
  //************************************************************
  initial begin : main
    logic [31:0] v;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    rd_reg(`DST_A_OT, v);
    chk("ot defaults", v, 32'h00000A00);
    step();
    chk("rdata idle", rdata, 32'h0);
    rd_reg(6'h3C, v);
    chk("unmapped", v, 32'h0);
    rd_reg(`DST_A_SPEED, v);
    chk("speed defaults", v, 32'h00143C3C);
    rd_reg(`DST_A_PUMP, v);
    chk("pump defaults", v, 32'h0005003C);
    wr_reg(`DST_A_CTRL, 32'h51);
    pins.power_ok <= 1'b1;
    load_pct <= 8'h50;
    step(4);
    start_cmd <= 1'b1;
    for (i = 0; i < 20 && o.run_enable !== 1'b1; i++) step();
    start_cmd <= 1'b0;
    chk("run", o.run_enable, 1'b1);
    step(60);
    chk("alarm at level 0", o.ot_alarm, 1'b0);
    chk("fault at level 0", o.fault_code, `DST_FC_NONE);
    wr_reg(`DST_A_OT, 32'h0A32);
    for (i = 0; i < 60 && o.ot_alarm !== 1'b1; i++) step();
    chk("alarm", o.ot_alarm, 1'b1);
    chk("still running", o.run_enable, 1'b1);
    load_pct <= 8'h28;
    step(3);
    chk("alarm cleared", o.ot_alarm, 1'b0);
    load_pct <= 8'h50;
    step(8);
    chk("count restarts", o.ot_alarm, 1'b0);
    for (i = 0; i < 80 && o.fault_code !== `DST_FC_OT; i++) step();
    chk("ot fault", o.fault_code, `DST_FC_OT);
    step(2);
    chk("output off", o.run_enable, 1'b0);
    wr_reg(`DST_A_OT, 32'h0A00);
    wr_reg(`DST_A_CMD, 32'h1);
    wr_reg(`DST_A_SPEED, 32'h00020101);
    wr_reg(`DST_A_PUMP, 32'h00010001);
    start_cmd <= 1'b1;
    for (i = 0; i < 20 && o.run_enable !== 1'b1; i++) step();
    start_cmd <= 1'b0;
    chk("rerun", o.run_enable, 1'b1);
    at_high <= 1'b1;
    for (i = 0; i < 80 && o.pump === 2'b00; i++) step();
    chk("pump added", o.pump, 2'b01);
    at_high <= 1'b0;
    for (i = 0; i < 2600 && o.pump !== 2'b00; i++) step();
    chk("interlock", o.pump, 2'b00);
    for (i = 0; i < 60 && o.pump === 2'b00; i++) step();
    chk("duty swapped", o.pump, 2'b10);
    at_low <= 1'b1;
    for (i = 0; i < 80 && o.pump !== 2'b00; i++) step();
    chk("pump removed", o.pump, 2'b00);
    at_low <= 1'b0;
    pins.pid_in <= 1'b1;
    step(5);
    chk("pid on", o.pid_en, 1'b1);
    chk("deriv off", o.pid_d_en, 1'b0);
    wr_reg(`DST_A_PIDT, 32'h00050032);
    step(2);
    chk("deriv on", o.pid_d_en, 1'b1);
    pins.pid_in <= 1'b0;
    step(5);
    chk("pid off", o.pid_en, 1'b0);
    chk("deriv off", o.pid_d_en, 1'b0);
    wr_reg(`DST_A_ESAVE, 32'h5);
    const_speed <= 1'b1;
    step(3);
    chk("esave const", o.esave_en, 1'b1);
    const_speed <= 1'b0;
    step(3);
    chk("esave ramp", o.esave_en, 1'b0);
    sleep_req <= 1'b1;
    step(3);
    chk("sleep hold", o.sleep_hold, 1'b1);
    step(90);
    chk("sleep over", o.sleep_hold, 1'b0);
    sleep_req <= 1'b0;
    pins.power_ok <= 1'b0;
    step(8);
    pins.power_ok <= 1'b1;
    for (i = 0; i < 40 && o.track_start !== 1'b1; i++) step();
    chk("track restart", o.track_start, 1'b1);
    for (i = 0; i < 20 && o.run_enable !== 1'b1; i++) step();
    chk("back running", o.run_enable, 1'b1);
    wr_reg(`DST_A_COUNT, 32'h1234);
    pins.power_ok <= 1'b0;
    step(40);
    pins.power_ok <= 1'b1;
    step(20);
    chk("long outage", o.run_enable, 1'b0);
    rd_reg(`DST_A_STAT, v);
    chk("stop state", v[6:4], 3'h0);
    rd_reg(`DST_A_COUNT, v);
    chk("count lost", v, 32'h0);
    // one automatic restart allowed, one restart tick of delay
    wr_reg(`DST_A_RST, 32'h00010501);
    start_cmd <= 1'b1;
    for (i = 0; i < 20 && o.run_enable !== 1'b1; i++) step();
    start_cmd <= 1'b0;
    pins.oc <= 1'b1;
    step(4);
    pins.oc <= 1'b0;
    chk("oc fault", o.fault_code, `DST_FC_OC);
    for (i = 0; i < 40 && o.run_enable !== 1'b1; i++) step();
    chk("auto restart", o.run_enable, 1'b1);
    pins.oc <= 1'b1;
    step(4);
    pins.oc <= 1'b0;
    step(20);
    rd_reg(`DST_A_STAT, v);
    chk("locked", v[6:4], 3'h4);
    chk("locked off", o.run_enable, 1'b0);
    close_out();
  end
endmodule
